// ===== src/rtcmy_month_year.sv
// month and year counting stage of the calendar clock, apb slave
//
// Functional notes
// - month holds bcd 01 to 12
// - day overflow advances month by one
// - pending month write beats day overflow
// - out-of-range value repaired after one period
// - writes buffered, land within two slow ticks
// - month resets to 01
// - year holds bcd 00 to 99
// - month overflow advances year by one
// - year multiple of four is leap
// - pending year write beats month overflow
// - year resets to 00
`include "rtcmy_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module rtcmy_month_year (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    // apb slave
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [`RTCMY_ADDR_W-1:0]  paddr,
    input  wire logic [31:0]               pwdata,
    input  wire logic [3:0]                pstrb,
    output logic [31:0]                    prdata,
    output logic                           pready,
    output logic                           pslverr,
    // counting clock, sampled as a plain input
    input  wire logic                      clk_32k,
    // carry in from the day counter
    input  wire logic                      day_ovf,
    // calendar results
    output logic [7:0]                     month_bcd,
    output logic [7:0]                     year_bcd,
    output logic                           leap_year,
    output logic                           year_ovf
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------

    rtcmy_pkg::rtcmy_top_st_t s_q;
    rtcmy_pkg::rtcmy_top_st_t s_d;

    rtcmy_pkg::rtcmy_acc_t    acc;
    logic                     tick;
    logic                     setup;
    logic                     wr_fire;
    logic                     year_is_leap;
    logic [7:0]               status;

    // one interface per counter
    rtcmy_cnt_if mon_if ();
    rtcmy_cnt_if yr_if ();

    // ------------------------------------------------------------
    // slow clock edge detection
    // ------------------------------------------------------------

    // every buffered write waits for this pulse
    rtcmy_tick_gen u_tick (
        .pclk    (pclk),
        .presetn (presetn),
        .clk_32k (clk_32k),
        .tick    (tick)
    );

    // ------------------------------------------------------------
    // month counter
    // ------------------------------------------------------------

    // only bits 4:0 exist, so bits 7:5 always read zero
    rtcmy_bcd_cnt #(
        .MIN_VAL (`RTCMY_MONTH_MIN),
        .MAX_VAL (`RTCMY_MONTH_MAX),
        .MASK    (`RTCMY_MONTH_MASK),
        .RST_VAL (`RTCMY_MONTH_RST)
    ) u_month (
        .pclk    (pclk),
        .presetn (presetn),
        .c       (mon_if.cnt)
    );

    // ------------------------------------------------------------
    // year counter
    // ------------------------------------------------------------

    rtcmy_bcd_cnt #(
        .MIN_VAL (`RTCMY_YEAR_MIN),
        .MAX_VAL (`RTCMY_YEAR_MAX),
        .MASK    (`RTCMY_YEAR_MASK),
        .RST_VAL (`RTCMY_YEAR_RST)
    ) u_year (
        .pclk    (pclk),
        .presetn (presetn),
        .c       (yr_if.cnt)
    );

    // ------------------------------------------------------------
    // counter control
    // ------------------------------------------------------------

    // a buffered value moves into its counter on the next slow edge
    assign mon_if.tick     = tick;
    assign mon_if.load     = s_q.mon_pend & tick;
    assign mon_if.load_val = s_q.month_buf;

    // day carry is dropped while a month write is in flight
    assign mon_if.inc      = day_ovf & ~s_q.mon_pend;

    assign yr_if.tick      = tick;
    assign yr_if.load      = s_q.yr_pend & tick;
    assign yr_if.load_val  = s_q.year_buf;

    // month carry is dropped while a year write is in flight
    assign yr_if.inc       = mon_if.ovf & ~s_q.yr_pend;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------

    // full-word compare; anything else is answered with an error
    always_comb begin
        if (!psel) begin
            acc = rtcmy_pkg::ACC_NONE;
        end else if (paddr == `RTCMY_ADDR_MONTH) begin
            acc = rtcmy_pkg::ACC_MONTH;
        end else if (paddr == `RTCMY_ADDR_YEAR) begin
            acc = rtcmy_pkg::ACC_YEAR;
        end else if (paddr == `RTCMY_ADDR_STAT) begin
            acc = rtcmy_pkg::ACC_STAT;
        end else begin
            acc = rtcmy_pkg::ACC_BAD;
        end
    end

    // setup phase samples read data; access phase commits writes
    assign setup   = psel & ~penable;

    // a write without the low byte lane is a partial access, ignored
    assign wr_fire = psel & penable & pwrite & pstrb[0];

    // ------------------------------------------------------------
    // leap year detection
    // ------------------------------------------------------------

    // bcd multiple of four: even tens with units 0/4/8, odd tens 2/6
    always_comb begin
        if (yr_if.value[4] == 1'b0) begin
            year_is_leap = (yr_if.value[3:0] == 4'h0)
                        || (yr_if.value[3:0] == 4'h4)
                        || (yr_if.value[3:0] == 4'h8);
        end else begin
            year_is_leap = (yr_if.value[3:0] == 4'h2)
                        || (yr_if.value[3:0] == 4'h6);
        end
    end

    // ------------------------------------------------------------
    // status word
    // ------------------------------------------------------------

    always_comb begin
        status                       = `RTCMY_STAT_RST;
        status[`RTCMY_STAT_MON_PEND] = s_q.mon_pend;
        status[`RTCMY_STAT_YR_PEND]  = s_q.yr_pend;
        status[`RTCMY_STAT_LEAP]     = s_q.leap;
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------

    always_comb begin
        s_d          = s_q;
        s_d.leap     = year_is_leap;
        s_d.year_ovf = yr_if.ovf;

        // read data is built in setup so it comes from a flop
        if (setup) begin
            s_d.rdata  = 32'h0000_0000;
            s_d.slverr = 1'b0;
            case (acc)
                rtcmy_pkg::ACC_MONTH: begin
                    s_d.rdata[7:0] = mon_if.value;
                end
                rtcmy_pkg::ACC_YEAR: begin
                    s_d.rdata[7:0] = yr_if.value;
                end
                rtcmy_pkg::ACC_STAT: begin
                    s_d.rdata[7:0] = status;
                end
                rtcmy_pkg::ACC_BAD: begin
                    s_d.slverr = 1'b1;
                end
                default: begin
                    s_d.slverr = 1'b0;
                end
            endcase
        end

        // completed transfers empty the buffers
        if (mon_if.load) begin
            s_d.mon_pend = 1'b0;
        end
        if (yr_if.load) begin
            s_d.yr_pend = 1'b0;
        end

        // a write in the load cycle re-arms, so the newest value wins
        if (wr_fire) begin
            case (acc)
                rtcmy_pkg::ACC_MONTH: begin
                    s_d.month_buf = pwdata[7:0] & `RTCMY_MONTH_MASK;
                    s_d.mon_pend  = 1'b1;
                end
                rtcmy_pkg::ACC_YEAR: begin
                    s_d.year_buf = pwdata[7:0];
                    s_d.yr_pend  = 1'b1;
                end
                default: begin
                    s_d.mon_pend = s_d.mon_pend;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q.month_buf <= `RTCMY_MONTH_RST;
            s_q.year_buf  <= `RTCMY_YEAR_RST;
            s_q.mon_pend  <= 1'b0;
            s_q.yr_pend   <= 1'b0;
            s_q.rdata     <= 32'h0000_0000;
            s_q.slverr    <= 1'b0;
            s_q.leap      <= 1'b1; // year 00 is leap
            s_q.year_ovf  <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------

    // zero wait states; data was captured in the setup cycle
    assign pready    = 1'b1;
    assign prdata    = s_q.rdata;
    assign pslverr   = s_q.slverr & psel & penable;

    // counter values come straight from the counter flops
    assign month_bcd = mon_if.value;
    assign year_bcd  = yr_if.value;
    assign leap_year = s_q.leap;
    assign year_ovf  = s_q.year_ovf;

endmodule

`default_nettype wire

// ===== common/rtcmy_defines.svh
// register map, reset values and counting limits of the month/year stage
`ifndef RTCMY_DEFINES_SVH
`define RTCMY_DEFINES_SVH

// register indices; byte address is four times the index
`define RTCMY_IDX_MONTH    20'hFFF97
`define RTCMY_IDX_YEAR     20'hFFF98
`define RTCMY_IDX_STAT     20'hFFF99
`define RTCMY_ADDR_W       22
`define RTCMY_ADDR_MONTH   {`RTCMY_IDX_MONTH, 2'b00}
`define RTCMY_ADDR_YEAR    {`RTCMY_IDX_YEAR, 2'b00}
`define RTCMY_ADDR_STAT    {`RTCMY_IDX_STAT, 2'b00}

// reset values
`define RTCMY_MONTH_RST    8'h01
`define RTCMY_YEAR_RST     8'h00
`define RTCMY_STAT_RST     8'h00

// legal ranges and implemented bits, all in bcd
`define RTCMY_MONTH_MIN    8'h01
`define RTCMY_MONTH_MAX    8'h12
`define RTCMY_MONTH_MASK   8'h1F
`define RTCMY_YEAR_MIN     8'h00
`define RTCMY_YEAR_MAX     8'h99
`define RTCMY_YEAR_MASK    8'hFF

// status register fields
`define RTCMY_STAT_MON_PEND 0
`define RTCMY_STAT_YR_PEND  1
`define RTCMY_STAT_LEAP     2

// latest transfer of a written value, in 32.768 kHz periods
`define RTCMY_XFER_TICKS_MAX 2

`endif

// ===== common/rtcmy_pkg.sv
// types shared by the month/year counting stage
package rtcmy_pkg;

    // decoded target of an apb access
    typedef enum logic [2:0] {
        ACC_NONE,
        ACC_MONTH,
        ACC_YEAR,
        ACC_STAT,
        ACC_BAD
    } rtcmy_acc_t;

    // state of one bcd counter
    typedef struct packed {
        logic [7:0] value;
        logic       ovf;
    } rtcmy_cnt_st_t;

    // state of the 32.768 kHz edge detector
    typedef struct packed {
        logic prev;
        logic tick;
    } rtcmy_tick_st_t;

    // state of the top level
    typedef struct packed {
        logic [7:0]  month_buf;
        logic [7:0]  year_buf;
        logic        mon_pend;
        logic        yr_pend;
        logic [31:0] rdata;
        logic        slverr;
        logic        leap;
        logic        year_ovf;
    } rtcmy_top_st_t;

endpackage

// ===== common/rtcmy_cnt_if.sv
// control and result signals between the top and one bcd counter
`timescale 1ns/1ps
`default_nettype none

interface rtcmy_cnt_if;
    logic       tick;
    logic       inc;
    logic       load;
    logic [7:0] load_val;
    logic [7:0] value;
    logic       ovf;

    modport ctrl (
        output tick,
        output inc,
        output load,
        output load_val,
        input  value,
        input  ovf
    );

    modport cnt (
        input  tick,
        input  inc,
        input  load,
        input  load_val,
        output value,
        output ovf
    );
endinterface

`default_nettype wire

// ===== src/rtcmy_tick_gen.sv
// one-cycle pulse on each rising edge of the 32.768 kHz counting clock
`timescale 1ns/1ps
`default_nettype none

module rtcmy_tick_gen (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic clk_32k,
    output logic      tick
);
    rtcmy_pkg::rtcmy_tick_st_t s_q;
    rtcmy_pkg::rtcmy_tick_st_t s_d;

    // input is synchronous to pclk, so a plain edge compare is safe
    always_comb begin
        s_d      = s_q;
        s_d.prev = clk_32k;
        s_d.tick = clk_32k & ~s_q.prev;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick = s_q.tick;
endmodule

`default_nettype wire

// ===== src/rtcmy_bcd_cnt.sv
// two-digit bcd counter with load, wrap, range repair and carry out
`timescale 1ns/1ps
`default_nettype none

module rtcmy_bcd_cnt #(
    parameter logic [7:0] MIN_VAL = 8'h00,
    parameter logic [7:0] MAX_VAL = 8'h99,
    parameter logic [7:0] MASK    = 8'hFF,
    parameter logic [7:0] RST_VAL = 8'h00
) (
    input  wire logic  pclk,
    input  wire logic  presetn,
    rtcmy_cnt_if.cnt   c
);
    rtcmy_pkg::rtcmy_cnt_st_t s_q;
    rtcmy_pkg::rtcmy_cnt_st_t s_d;
    logic                     legal;
    logic [7:0]               inc_val;

    // legal means both digits decimal, unused bits clear, inside range
    always_comb begin
        legal = (s_q.value[3:0] <= 4'h9) && (s_q.value[7:4] <= 4'h9)
             && ((s_q.value & ~MASK) == 8'h00)
             && (s_q.value >= MIN_VAL) && (s_q.value <= MAX_VAL);
        if (s_q.value[3:0] == 4'h9) begin
            inc_val = {s_q.value[7:4] + 4'h1, 4'h0};
        end else begin
            inc_val = {s_q.value[7:4], s_q.value[3:0] + 4'h1};
        end
    end

    // load beats increment, so a coinciding carry in is dropped
    always_comb begin
        s_d     = s_q;
        s_d.ovf = 1'b0;
        if (c.load) begin
            s_d.value = c.load_val & MASK;
        end else if (c.inc) begin
            if (s_q.value == MAX_VAL) begin
                s_d.value = MIN_VAL;
                s_d.ovf   = 1'b1;
            end else if (!legal) begin
                s_d.value = MIN_VAL;
            end else begin
                s_d.value = inc_val;
            end
        end else if (c.tick && !legal) begin
            s_d.value = MIN_VAL;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q.value <= RST_VAL;
            s_q.ovf   <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    assign c.value = s_q.value;
    assign c.ovf   = s_q.ovf;
endmodule

`default_nettype wire

// ===== tb/rtcmy_properties.sv
// concurrent checks on the ports of the month/year stage
`include "rtcmy_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module rtcmy_properties (
    input wire logic                     pclk,
    input wire logic                     presetn,
    input wire logic                     psel,
    input wire logic                     penable,
    input wire logic                     pwrite,
    input wire logic [`RTCMY_ADDR_W-1:0] paddr,
    input wire logic [31:0]              pwdata,
    input wire logic [3:0]               pstrb,
    input wire logic [31:0]              prdata,
    input wire logic                     pready,
    input wire logic                     pslverr,
    input wire logic                     clk_32k,
    input wire logic                     day_ovf,
    input wire logic [7:0]               month_bcd,
    input wire logic [7:0]               year_bcd,
    input wire logic                     leap_year,
    input wire logic                     year_ovf
);
    logic       prev_q, tick_q, mp_q, yp_q;
    logic [7:0] mbuf_q;
    wire logic  wr = psel && penable && pwrite && pstrb[0];

    function automatic logic lg(input logic [7:0] v, input logic [7:0] hi);
        return v[3:0] <= 4'h9 && v[7:4] <= 4'h9 && v <= hi;
    endfunction

    // bcd step with wrap from hi back to lo
    function automatic logic [7:0] inc(input logic [7:0] v, hi, lo);
        return (v == hi) ? lo : (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
    endfunction

    // odd tens digit needs units 2 or 6, even tens 0, 4 or 8
    function automatic logic lp(input logic [7:0] v);
        return v[4] ? (v[3:0] == 4'h2 || v[3:0] == 4'h6)
                    : (v[3:0] == 4'h0 || v[3:0] == 4'h4 || v[3:0] == 4'h8);
    endfunction

    // shadow of the slow tick and the pending writes, built the same way as in the design so it runs in step with it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_q <= 1'b0;
            tick_q <= 1'b0;
            mp_q   <= 1'b0;
            yp_q   <= 1'b0;
            mbuf_q <= 8'h00;
        end else begin
            prev_q <= clk_32k;
            tick_q <= clk_32k && !prev_q;
            mp_q   <= (wr && paddr == `RTCMY_ADDR_MONTH) || (mp_q && !tick_q);
            yp_q   <= (wr && paddr == `RTCMY_ADDR_YEAR) || (yp_q && !tick_q);
            if (wr && paddr == `RTCMY_ADDR_MONTH) mbuf_q <= pwdata[7:0] & 8'h1F;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_RESET: assert property (disable iff (1'b0) !presetn |->
        month_bcd == 8'h01 && year_bcd == 8'h00) else $error("reset values wrong");
    AST_MON_INC: assert property (day_ovf && !mp_q && lg(month_bcd, 8'h12)
        && month_bcd != 8'h00 |=> month_bcd == inc($past(month_bcd), 8'h12, 8'h01))
        else $error("month step wrong");
    AST_MON_HOLD: assert property (day_ovf && mp_q && !tick_q |=> $stable(month_bcd))
        else $error("carry not dropped");
    AST_XFER: assert property (tick_q && mp_q |-> ##[1:2] month_bcd == mbuf_q)
        else $error("month write not landed");
    AST_YEAR_INC: assert property (day_ovf && month_bcd == 8'h12 && !mp_q && !yp_q
        && lg(year_bcd, 8'h99) |-> ##2 year_bcd == inc($past(year_bcd, 2), 8'h99, 8'h00))
        else $error("year step wrong");
    AST_LEAP: assert property (lg($past(year_bcd), 8'h99) |->
        leap_year == lp($past(year_bcd))) else $error("leap flag wrong");
    AST_YOVF: assert property ($rose(year_ovf) |-> $past(year_bcd) == 8'h00
        && $past(year_bcd, 2) == 8'h99 ##1 !year_ovf) else $error("year carry wrong");
    AST_SLVERR: assert property (psel && penable |-> pready && pslverr == !(paddr inside
        {`RTCMY_ADDR_MONTH, `RTCMY_ADDR_YEAR, `RTCMY_ADDR_STAT})) else $error("bad error");
    AST_FIELDS: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h0
        && month_bcd[7:5] == 3'h0) else $error("reserved bits set");

    cover property (day_ovf && month_bcd == 8'h12);
    cover property ($rose(year_ovf));
    cover property (day_ovf && mp_q);
endmodule

`default_nettype wire

// ===== tb/testbench.sv
// self-checking bench for the month/year stage
`include "rtcmy_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module testbench;
    localparam logic [21:0] AM = `RTCMY_ADDR_MONTH;
    localparam logic [21:0] AY = `RTCMY_ADDR_YEAR;
    logic        pclk, psel, penable, pwrite, day_ovf;
    // reset starts released so that its first fall is a real edge
    logic        presetn = 1'b1;
    logic        clk_32k = 1'b0;
    logic        pready, pslverr, leap_year, year_ovf, er;
    logic [21:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb;
    logic [7:0]  month_bcd, year_bcd;
    int          fails, num_checks, m, y, n32, novf, seed, v, i;

    rtcmy_month_year u_rtcmy_month_year (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .clk_32k(clk_32k),
        .day_ovf(day_ovf), .month_bcd(month_bcd), .year_bcd(year_bcd),
        .leap_year(leap_year), .year_ovf(year_ovf));

    // bus clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // counting clock of 40 pclk periods, far too fast, to keep the run short
    always @(posedge pclk) begin
        n32 <= (n32 == 19) ? 0 : n32 + 1;
        if (n32 == 19) clk_32k <= ~clk_32k;
        if (year_ovf === 1'b1) novf <= novf + 1;
    end

    function automatic logic [7:0] bcd(input int x);
        return 8'((x / 10) * 16 + x % 10);
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h, want %h", $time, got, exp);
        end
    endtask

    task automatic summarize;
        $display("checks %0d, mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // one apb transfer, then an idle cycle
    task automatic apb(input logic w, input logic [21:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        // only the watchdog ends a wait for pready
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic cmp;
        chk(32'(month_bcd), 32'(bcd(m)));
        chk(32'(year_bcd), 32'(bcd(y)));
        chk(32'(leap_year), 32'(y % 4 == 0));
    endtask

    // one day carry; model drops it where a write waits
    task automatic day(input bit mp, input bit yp);
        day_ovf <= 1'b1;
        @(posedge pclk);
        day_ovf <= 1'b0;
        if (!mp && m == 12) begin
            m = 1;
            if (!yp) y = (y + 1) % 100;
        end else if (!mp) m++;
        repeat (5) @(posedge pclk);
    endtask

    // write a counter, wait out load and repair, read it back
    task automatic setr(input logic yr, input logic [7:0] d);
        logic [7:0] b;
        b = yr ? d : d & 8'h1F;
        apb(1'b1, yr ? AY : AM, 32'(d), 4'hF);
        repeat (100) @(posedge pclk);
        if (yr) y = (b[3:0] < 10 && b[7:4] < 10) ? b[7:4] * 10 + b[3:0] : 0;
        else m = (b[3:0] < 10 && b > 0 && b <= 8'h12) ? b[7:4] * 10 + b[3:0] : 1;
        cmp;
        apb(1'b0, yr ? AY : AM, 32'h0, 4'hF);
        chk(rd, 32'(yr ? bcd(y) : bcd(m)));
    endtask

    // start a write well clear of the next slow tick
    task automatic align;
        @(posedge clk_32k);
        repeat (3) @(posedge pclk);
    endtask

    initial begin
        {psel, penable, pwrite, day_ovf} = '0;
        {paddr, pwdata, pstrb} = '0;
        {fails, num_checks} = '0;
        presetn <= 1'b0;
        seed = 32'hCF3E;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        m = 1;
        y = 0;
        cmp;
        apb(1'b0, AM, 32'h0, 4'hF);
        chk(rd, 32'h01);
        apb(1'b0, AY, 32'h0, 4'hF);
        chk(rd, 32'h00);
        for (i = 0; i < 13; i++) begin
            day(0, 0);
            cmp;
        end
        setr(1'b1, 8'h99);
        setr(1'b0, 8'h12);
        v = novf;
        day(0, 0);
        cmp;
        chk(32'(novf - v), 32'h1);
        $display("test counting done");
        align;
        apb(1'b1, AM, 32'h05, 4'hF);
        apb(1'b0, `RTCMY_ADDR_STAT, 32'h0, 4'hF);
        chk(rd, {29'h0, y % 4 == 0, 2'b01});
        day(1, 0);
        repeat (100) @(posedge pclk);
        m = 5;
        cmp;
        setr(1'b0, 8'h12);
        align;
        apb(1'b1, AY, 32'h33, 4'hF);
        day(0, 1);
        repeat (100) @(posedge pclk);
        y = 33;
        cmp;
        setr(1'b0, 8'h13);
        setr(1'b0, 8'h1A);
        setr(1'b1, 8'hAB);
        for (i = 0; i < 8; i++) begin
            v = $unsigned($random(seed)) % 100;
            setr(1'b1, bcd(v));
        end
        $display("test writes done");
        apb(1'b1, AM, 32'h07, 4'h0);
        repeat (100) @(posedge pclk);
        cmp;
        apb(1'b0, `RTCMY_ADDR_STAT + 22'h4, 32'h0, 4'hF);
        chk(32'(er), 32'h1);
        chk(rd, 32'h0);
        apb(1'b0, `RTCMY_ADDR_STAT, 32'h0, 4'hF);
        chk(rd, {29'h0, y % 4 == 0, 2'b00});
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        m = 1;
        y = 0;
        cmp;
        $display("test reset done");
        summarize;
    end

    // a hang counts as a mismatch
    initial begin
        #400us;
        fails++;
        summarize;
    end
endmodule

bind rtcmy_month_year rtcmy_properties u_rtcmy_properties (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .clk_32k(clk_32k),
    .day_ovf(day_ovf), .month_bcd(month_bcd), .year_bcd(year_bcd),
    .leap_year(leap_year), .year_ovf(year_ovf));

`default_nettype wire
